/* port_pin_config_and_wake_map.vh */
`ifndef PORT_PIN_CONFIG_AND_WAKE_MAP_VH
`define PORT_PIN_CONFIG_AND_WAKE_MAP_VH

// Register byte offsets, one aligned 32-bit word each
`define OFS_PORT6_DATA 8'h00
`define OFS_PORT6_DIRECTION 8'h04
`define OFS_PORT7_DATA 8'h08
`define OFS_PORT7_DIRECTION 8'h0C
`define OFS_PORT7_PULLUP 8'h10
`define OFS_PORT9_DATA 8'h14
`define OFS_PORT9_DIRECTION 8'h18
`define OFS_PORTC_DATA 8'h1C
`define OFS_PORTC_DIRECTION 8'h20
`define OFS_WAKE_CTRL 8'h24
`define OFS_STATUS 8'h28

// Option word field positions
`define OPT_ROM_PROTECT 0
`define OPT_RC_FREQ 4
`define OPT_OSC_LO 5
`define OPT_OSC_HI 6
`define OPT_P70_SEL 7
`define OPT_RESET_PIN_SEL 8
`define OPT_WIDTH 13

// Option word value in force until the strap is caught
`define OPT_RESET 13'h1E06

// Wake control register fields
`define WC_MASK_LSB 0
`define WC_MASK_MSB 7
`define WC_EDGE_RISE 8
`define WC_PWR_BIT6 9
`define WC_PWR_BIT7 10
`define WC_PULSE1_EN 11
`define WC_PULSE2_EN 12
`define WC_WDT_EN 13
`define WC_WIDTH 14

// Interrupt mask bits that enable wake-up edges
`define MASK_P70 3
`define MASK_P71 4
`define MASK_P73 7

// Status register fields
`define ST_SLEEP 16
`define ST_CAUSE_LSB 17
`define ST_XTAL 20
`define ST_ERC 21
`define ST_IRC 22

// Reset values of port registers
`define DATA_RESET 8'h00
`define DIR_RESET 8'hFF
`define PULLUP_RESET 8'h00

// Bits of port 7 that exist as pins
`define P7_PIN_MASK 8'h7B

`endif

/* port_pin_config_and_wake.v */
// The APB register port and the register addresses were left to the implementer.
`include "port_pin_config_and_wake_map.vh"
`default_nettype none

// Overview of operation
// - Decode oscillator mode from two option bits
// - RC clock 2MHz or 4MHz by option
// - Port 70 function from mode and select
// - Port 71 is reset pin or input
// - ROM access allowed only when protect bit set
// - Tri-state pins with readable direction registers
// - Ports 60/61 are crystal pins in crystal mode
// - RC modes ignore port 70 select bit
// - Port 71 input only, no pull-up
// - Port 70 pull-up only as GPIO
// - Reset on power-on, watchdog, reset pin
// - Reset clears PC and watchdog, keeps oscillator
// - Power-on clears upper bits of registers 3/4
// - Sleep instruction stops core and crystal only when both power control bits are zero
// - Sleep wake sources cause full reset
// - Port 70 wake, mask bit 3, selectable edge
// - Port 71 wake, mask bit 4, falling
// - Port 73 wake, mask bit 7, falling
// - Pulse enable forces port C pin output
module port_pin_config_and_wake (
  input wire mclk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [12:0] optionWord,
  input wire sleepInstr,
  input wire wdtTimeout,
  input wire pulse1Out,
  input wire pulse2Out,
  input wire [5:0] port6In,
  output wire [5:0] port6Out,
  output wire [5:0] port6Oe,
  input wire [7:0] port7In,
  output wire [7:0] port7Out,
  output wire [7:0] port7Oe,
  output wire [7:0] port7PullEn,
  input wire [7:0] port9In,
  output wire [7:0] port9Out,
  output wire [7:0] port9Oe,
  input wire [1:0] portcIn,
  output wire [1:0] portcOut,
  output wire [1:0] portcOe,
  output wire internalRcMode,
  output wire externalRcMode,
  output wire crystalMode,
  output wire rcFreq4m,
  output wire pllEnable,
  output wire pllFilterPin,
  output wire pin70OscIn,
  output wire resetPinMode,
  output wire romAccessEnable,
  output wire chipReset,
  output wire pcClear,
  output wire wdtClear,
  output wire wdtEnable,
  output wire upperRegClear,
  output wire sleepActive,
  output wire crystalStop
);

  // Pin bus: {portC[1:0], port9, port7, 2'b00, port6}
  localparam PW = 26;
  localparam P7B = 8;
  localparam P9B = 16;
  localparam PCB = 24;

  // Read mix: pin level for inputs, latch for outputs
  function [7:0] readMix;
    input [7:0] latch;
    input [7:0] pin;
    input [7:0] dirIn;
    begin
      readMix = (dirIn & pin) | (~dirIn & latch);
    end
  endfunction

  reg [12:0] option_reg; // Caught option word
  reg optValid_reg; // Option caught since power-on
  reg [7:0] p6Data_reg;
  reg [7:0] p6Dir_reg; // 1 = input
  reg [7:0] p7Data_reg;
  reg [7:0] p7Dir_reg;
  reg [7:0] p7Pull_reg;
  reg [7:0] p9Data_reg;
  reg [7:0] p9Dir_reg;
  reg [7:0] pcData_reg;
  reg [7:0] pcDir_reg;
  reg [13:0] wake_reg; // Wake control fields
  reg [PW-1:0] sync1_reg; // First stage, read only by stage two
  reg [PW-1:0] sync2_reg;
  reg [PW-1:0] sync3_reg;
  reg [PW-1:0] filt_reg; // Agreed pin levels
  reg [7:0] prevP7_reg; // Previous agreed port 7 levels
  reg sleep_reg;
  reg reset_reg; // Any-reset pulse or level
  reg porLike_reg; // Power-on class reset
  reg [2:0] cause_reg; // {pin, edge, watchdog}
  reg [31:0] rdata_reg;
  reg err_reg;

  wire [PW-1:0] pinsIn;
  wire [PW-1:0] filt_next;
  wire xtal;
  wire erc;
  wire internal_rc_mode;
  wire p70Gp;
  wire p71Reset;
  wire [7:0] p6Pins;
  wire [7:0] p7Pins;
  wire [7:0] p9Pins;
  wire [7:0] pcPins;
  wire pinResetLow;
  wire wdtResetAwake;
  wire edge70;
  wire edge71;
  wire edge73;
  wire edgeWake;
  wire wakeEvent;
  wire anyReset;
  wire apbWrite;
  wire apbSetup;
  reg [31:0] rdMux;
  reg rdErr;

  assign pinsIn = {portcIn, port9In, port7In, 2'b00, port6In};

  // Mode decode; high upper bit means crystal whatever the lower
  assign xtal = option_reg[`OPT_OSC_HI];
  assign erc = ~option_reg[`OPT_OSC_HI] & option_reg[`OPT_OSC_LO];
  assign internal_rc_mode = ~option_reg[`OPT_OSC_HI] & ~option_reg[`OPT_OSC_LO];
  assign internalRcMode = internal_rc_mode;
  assign externalRcMode = erc;
  assign crystalMode = xtal;
  assign rcFreq4m = option_reg[`OPT_RC_FREQ];
  // Select bit only matters in crystal mode
  assign p70Gp = internal_rc_mode | (xtal & ~option_reg[`OPT_P70_SEL]);
  assign pllFilterPin = xtal & option_reg[`OPT_P70_SEL];
  assign pllEnable = xtal & option_reg[`OPT_P70_SEL];
  assign pin70OscIn = erc;
  assign p71Reset = ~option_reg[`OPT_RESET_PIN_SEL];
  assign resetPinMode = p71Reset;
  assign romAccessEnable = option_reg[`OPT_ROM_PROTECT];

  // Catch the option strap once after power-on release
  always @(posedge mclk) begin
    if (rst) begin
      option_reg <= `OPT_RESET;
      optValid_reg <= 1'b0;
    end else if (!optValid_reg) begin
      option_reg <= optionWord;
      optValid_reg <= 1'b1;
    end
  end

  // A level counts once stages two and three agree
  assign filt_next = (sync2_reg & sync3_reg) |
    (filt_reg & (sync2_reg ^ sync3_reg));

  // Three-stage pin synchroniser; idle high so reset pin is quiet
  always @(posedge mclk) begin
    if (rst) begin
      sync1_reg <= {PW{1'b1}};
      sync2_reg <= {PW{1'b1}};
      sync3_reg <= {PW{1'b1}};
      filt_reg <= {PW{1'b1}};
      prevP7_reg <= 8'hFF;
    end else begin
      sync1_reg <= pinsIn;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      filt_reg <= filt_next;
      prevP7_reg <= filt_reg[P7B+7:P7B];
    end
  end

  assign p6Pins = filt_reg[7:0];
  assign p7Pins = filt_reg[P7B+7:P7B];
  assign p9Pins = filt_reg[P9B+7:P9B];
  assign pcPins = {5'b00000, filt_reg[PCB+1:PCB], 1'b0};

  // Reset sources while awake
  assign pinResetLow = p71Reset & ~p7Pins[1];
  // Green or normal mode only; in sleep the timeout is a wake
  assign wdtResetAwake = wdtTimeout & wake_reg[`WC_WDT_EN] &
    ~sleep_reg;

  // Edge detectors on agreed levels, one cycle per edge
  assign edge70 = wake_reg[`MASK_P70] & (wake_reg[`WC_EDGE_RISE] ?
    (p7Pins[0] & ~prevP7_reg[0]) :
    (~p7Pins[0] & prevP7_reg[0]));
  assign edge71 = wake_reg[`MASK_P71] & ~p7Pins[1] &
    prevP7_reg[1];
  assign edge73 = wake_reg[`MASK_P73] & ~p7Pins[3] &
    prevP7_reg[3];
  assign edgeWake = edge70 | edge71 | edge73;
  // Only watchdog, pin edges and reset pin wake; no timer input exists
  assign wakeEvent = sleep_reg & (wdtTimeout | edgeWake |
    pinResetLow);
  assign anyReset = wdtResetAwake | pinResetLow | wakeEvent;

  // Reset generation; a wake is treated as a power-on reset
  always @(posedge mclk) begin
    if (rst) begin
      reset_reg <= 1'b1;
      porLike_reg <= 1'b1;
      cause_reg <= 3'h0;
    end else begin
      reset_reg <= anyReset;
      porLike_reg <= wakeEvent;
      if (anyReset) begin
        cause_reg <= {pinResetLow, edgeWake & sleep_reg, wdtTimeout};
      end
    end
  end

  // One reset strobe serves PC, watchdog counter and prescaler
  assign chipReset = reset_reg;
  assign pcClear = reset_reg;
  assign wdtClear = reset_reg;
  assign upperRegClear = porLike_reg;
  assign wdtEnable = wake_reg[`WC_WDT_EN];

  // Sleep state; both power control bits must be zero
  always @(posedge mclk) begin
    if (rst || reset_reg || anyReset) begin
      sleep_reg <= 1'b0;
    end else if (sleepInstr && !wake_reg[`WC_PWR_BIT7] &&
      !wake_reg[`WC_PWR_BIT6]) begin
      sleep_reg <= 1'b1;
    end
  end

  assign sleepActive = sleep_reg;
  // Oscillator kept running while a reset is in progress
  assign crystalStop = sleep_reg & xtal & ~reset_reg;

  assign apbWrite = psel & penable & pwrite;
  assign apbSetup = psel & ~penable;

  // Register file; any reset returns ports to inputs
  always @(posedge mclk) begin
    if (rst || reset_reg) begin
      p6Data_reg <= `DATA_RESET;
      p6Dir_reg <= `DIR_RESET;
      p7Data_reg <= `DATA_RESET;
      p7Dir_reg <= `DIR_RESET;
      p7Pull_reg <= `PULLUP_RESET;
      p9Data_reg <= `DATA_RESET;
      p9Dir_reg <= `DIR_RESET;
      pcData_reg <= `DATA_RESET;
      pcDir_reg <= `DIR_RESET;
      wake_reg <= 14'h0000;
    end else if (apbWrite) begin
      case (paddr)
        `OFS_PORT6_DATA: p6Data_reg <= pwdata[7:0];
        `OFS_PORT6_DIRECTION: p6Dir_reg <= pwdata[7:0];
        `OFS_PORT7_DATA: p7Data_reg <= pwdata[7:0];
        `OFS_PORT7_DIRECTION: p7Dir_reg <= pwdata[7:0];
        `OFS_PORT7_PULLUP: p7Pull_reg <= pwdata[7:0];
        `OFS_PORT9_DATA: p9Data_reg <= pwdata[7:0];
        `OFS_PORT9_DIRECTION: p9Dir_reg <= pwdata[7:0];
        `OFS_PORTC_DATA: pcData_reg <= pwdata[7:0];
        `OFS_PORTC_DIRECTION: pcDir_reg <= pwdata[7:0];
        `OFS_WAKE_CTRL: wake_reg <= pwdata[`WC_WIDTH-1:0];
        default: begin
        end
      endcase
    end
  end

  // Read decode; unmapped offsets answer with an error
  always @* begin
    rdMux = 32'h00000000;
    rdErr = 1'b0;
    case (paddr)
      `OFS_PORT6_DATA: begin
        // Crystal pins read zero, their data is undefined
        rdMux[7:0] = readMix(p6Data_reg, p6Pins, p6Dir_reg) &
          {2'b00, 4'hF, ~xtal, ~xtal};
      end
      `OFS_PORT6_DIRECTION: rdMux[7:0] = p6Dir_reg & 8'h3F;
      `OFS_PORT7_DATA: begin
        // Port 71 has no latch path, always the pin
        rdMux[7:0] = (readMix(p7Data_reg, p7Pins, p7Dir_reg) &
          8'h79) | (p7Pins & 8'h02);
      end
      `OFS_PORT7_DIRECTION: rdMux[7:0] = p7Dir_reg & 8'h79;
      `OFS_PORT7_PULLUP: rdMux[7:0] = p7Pull_reg & 8'h79;
      `OFS_PORT9_DATA: begin
        rdMux[7:0] = readMix(p9Data_reg, p9Pins, p9Dir_reg);
      end
      `OFS_PORT9_DIRECTION: rdMux[7:0] = p9Dir_reg;
      `OFS_PORTC_DATA: begin
        rdMux[7:0] = readMix(pcData_reg, pcPins, pcDir_reg) &
          8'h06;
      end
      `OFS_PORTC_DIRECTION: rdMux[7:0] = pcDir_reg & 8'h06;
      `OFS_WAKE_CTRL: rdMux[`WC_WIDTH-1:0] = wake_reg;
      `OFS_STATUS: begin
        rdMux[`OPT_WIDTH-1:0] = option_reg;
        rdMux[`ST_SLEEP] = sleep_reg;
        rdMux[`ST_CAUSE_LSB+2:`ST_CAUSE_LSB] = cause_reg;
        rdMux[`ST_XTAL] = xtal;
        rdMux[`ST_ERC] = erc;
        rdMux[`ST_IRC] = internal_rc_mode;
      end
      default: rdErr = 1'b1;
    endcase
  end

  // Read data caught in the setup cycle, held through access
  always @(posedge mclk) begin
    if (rst) begin
      rdata_reg <= 32'h00000000;
      err_reg <= 1'b0;
    end else if (apbSetup) begin
      rdata_reg <= pwrite ? 32'h00000000 : rdMux;
      err_reg <= rdErr;
    end
  end

  // Zero-wait slave
  assign pready = psel & penable;
  assign prdata = rdata_reg;
  assign pslverr = psel & penable & err_reg;

  // Port 6: crystal mode takes pins 60/61 off the port
  assign port6Out = p6Data_reg[5:0];
  assign port6Oe = ~p6Dir_reg[5:0] &
    {4'hF, ~xtal, ~xtal};

  // Port 7: 71 never drives; 70 drives only as GPIO
  assign port7Out = p7Data_reg & `P7_PIN_MASK;
  assign port7Oe = (~p7Dir_reg & 8'h78) |
    {7'h00, ~p7Dir_reg[0] & p70Gp};
  assign port7PullEn = (p7Pull_reg & 8'h78) |
    {7'h00, p7Pull_reg[0] & p70Gp};

  // Port 9: plain bidirectional byte
  assign port9Out = p9Data_reg;
  assign port9Oe = ~p9Dir_reg;

  // Port C: a pulse enable takes the pin as output
  assign portcOut[0] = wake_reg[`WC_PULSE1_EN] ? pulse1Out :
    pcData_reg[1];
  assign portcOut[1] = wake_reg[`WC_PULSE2_EN] ? pulse2Out :
    pcData_reg[2];
  assign portcOe[0] = wake_reg[`WC_PULSE1_EN] | ~pcDir_reg[1];
  assign portcOe[1] = wake_reg[`WC_PULSE2_EN] | ~pcDir_reg[2];

endmodule // port_pin_config_and_wake

`default_nettype wire

/* x_unused_none.v */
`default_nettype none
`default_nettype wire

/* pin_board.sv */
`default_nettype none
module pin_board #(
  parameter int W = 8
) (
  input wire logic mclk,
  input wire logic [W-1:0] pinOut,
  input wire logic [W-1:0] pinOe,
  input wire logic [W-1:0] pullEn,
  input wire logic [W-1:0] extVal,
  input wire logic [W-1:0] extEn,
  output logic [W-1:0] pinIn
);
  timeunit 1ns;
  timeprecision 1ns;
  // A floating pin wanders, so no stale level can pass as a good read
  logic [W-1:0] floatPat = '0;
  // Toggle pattern for undriven, unpulled pins
  always @(posedge mclk) begin
    floatPat <= ~floatPat;
  end
  // Chip driver wins, then board driver, then pull-up, else floating
  assign pinIn = (pinOe & pinOut) | (~pinOe & extEn & extVal) |
    (~pinOe & ~extEn & (pullEn | floatPat));
endmodule // pin_board
`default_nettype wire

/* port_pin_checks_props.sv */
`default_nettype none
module port_pin_checks (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [12:0] optionWord,
  input wire logic internalRcMode,
  input wire logic externalRcMode,
  input wire logic crystalMode,
  input wire logic rcFreq4m,
  input wire logic pllFilterPin,
  input wire logic pin70OscIn,
  input wire logic resetPinMode,
  input wire logic romAccessEnable,
  input wire logic chipReset,
  input wire logic pcClear,
  input wire logic wdtClear,
  input wire logic wdtEnable,
  input wire logic upperRegClear,
  input wire logic sleepActive,
  input wire logic crystalStop,
  input wire logic [5:0] port6Oe,
  input wire logic [7:0] port7Oe,
  input wire logic [7:0] port7PullEn
);
  timeunit 1ns;
  timeprecision 1ns;
  // One domain: clock and reset stated once
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Decodes are judged only after the strap was caught
  mode_decode_a: assert property (
    !$past(rst) |-> {internalRcMode, externalRcMode, crystalMode} ==
    {optionWord[6:5] == 2'h0, optionWord[6:5] == 2'h1, optionWord[6]})
    else $error("mode decode wrong");
  freq_sel_a: assert property (
    !$past(rst) |-> rcFreq4m == optionWord[4]) else $error("freq wrong");
  pin70_func_a: assert property (
    !$past(rst) |-> pllFilterPin == (optionWord[6] && optionWord[7]) &&
    pin70OscIn == (optionWord[6:5] == 2'h1)) else $error("p70 wrong");
  reset_pin_a: assert property (
    !$past(rst) |-> resetPinMode == !optionWord[8])
    else $error("reset pin mode wrong");
  rom_access_a: assert property (
    !$past(rst) |-> romAccessEnable == optionWord[0])
    else $error("rom access wrong");
  xtal_pins_a: assert property (
    crystalMode |-> port6Oe[1:0] == 2'h0) else $error("xtal pin driven");
  p71_input_a: assert property (
    port7Oe[1] == 1'h0 && port7PullEn[1] == 1'h0)
    else $error("p71 driven");
  pull_gpio_a: assert property (
    port7PullEn[0] |-> !pllFilterPin && !pin70OscIn)
    else $error("p70 pull wrong");
  reset_clear_a: assert property (
    chipReset |-> pcClear && wdtClear ##1 !wdtEnable)
    else $error("reset clear wrong");
  crystal_stop_a: assert property (
    crystalStop == (sleepActive && crystalMode && !chipReset))
    else $error("crystal stop wrong");
  wake_reset_a: assert property (
    $fell(sleepActive) |-> chipReset && upperRegClear)
    else $error("wake without reset");
endmodule // port_pin_checks
bind port_pin_config_and_wake port_pin_checks chk (.mclk, .rst,
  .optionWord, .internalRcMode, .externalRcMode, .crystalMode, .rcFreq4m,
  .pllFilterPin, .pin70OscIn, .resetPinMode, .romAccessEnable,
  .chipReset, .pcClear, .wdtClear, .wdtEnable, .upperRegClear,
  .sleepActive, .crystalStop, .port6Oe, .port7Oe, .port7PullEn);
`default_nettype wire

/* port_pin_config_and_wake_tb.sv */
`default_nettype none
module port_pin_config_and_wake_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [12:0] optionWord = 13'h1E06;
  logic sleepInstr = 1'h0, wdtTimeout = 1'h0;
  logic pulse1Out = 1'h0, pulse2Out = 1'h0;
  logic [7:0] ext7Val = 8'hFF; // Board levels on p70, p71, p73
  logic [7:0] ext7En = 8'h0B; // Board drives p70, p71, p73
  logic [7:0] ext9Val = 8'h3C, ext9En = 8'hFF, pull9 = 8'h00;
  logic [5:0] ext6Val = 6'h00, ext6En = 6'h00, pull6 = 6'h00;
  logic [1:0] extcVal = 2'h0, extcEn = 2'h0, pullc = 2'h0;
  wire [31:0] prdata;
  wire pready, pslverr;
  wire [5:0] port6In, port6Out, port6Oe;
  wire [7:0] port7In, port7Out, port7Oe, port7PullEn;
  wire [7:0] port9In, port9Out, port9Oe;
  wire [1:0] portcIn, portcOut, portcOe;
  wire internalRcMode, externalRcMode, crystalMode, rcFreq4m, pllEnable;
  wire pllFilterPin, pin70OscIn, resetPinMode, romAccessEnable;
  wire chipReset, pcClear, wdtClear, wdtEnable, upperRegClear;
  wire sleepActive, crystalStop;
  int mismatches = 0;
  int samples_checked = 0;
  logic [31:0] rdv;
  logic errv;
  // 20 MHz system clock
  always #25 mclk = ~mclk;
  port_pin_config_and_wake dut (.mclk, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .optionWord, .sleepInstr,
    .wdtTimeout, .pulse1Out, .pulse2Out, .port6In, .port6Out, .port6Oe,
    .port7In, .port7Out, .port7Oe, .port7PullEn, .port9In, .port9Out,
    .port9Oe, .portcIn, .portcOut, .portcOe, .internalRcMode,
    .externalRcMode, .crystalMode, .rcFreq4m, .pllEnable, .pllFilterPin,
    .pin70OscIn, .resetPinMode, .romAccessEnable, .chipReset, .pcClear,
    .wdtClear, .wdtEnable, .upperRegClear, .sleepActive, .crystalStop);
  // Board: p71 carries an external pull-up, port 9 sees 3C
  pin_board #(.W(6)) b6 (.mclk(mclk), .pinOut(port6Out), .pinOe(port6Oe),
    .pullEn(pull6), .extVal(ext6Val), .extEn(ext6En), .pinIn(port6In));
  pin_board #(.W(8)) b7 (.mclk(mclk), .pinOut(port7Out), .pinOe(port7Oe),
    .pullEn(port7PullEn), .extVal(ext7Val), .extEn(ext7En),
    .pinIn(port7In));
  pin_board #(.W(8)) b9 (.mclk(mclk), .pinOut(port9Out), .pinOe(port9Oe),
    .pullEn(pull9), .extVal(ext9Val), .extEn(ext9En), .pinIn(port9In));
  pin_board #(.W(2)) bc (.mclk(mclk), .pinOut(portcOut), .pinOe(portcOe),
    .pullEn(pullc), .extVal(extcVal), .extEn(extcEn), .pinIn(portcIn));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer; held until pready is seen at a rising edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'h1;
    // Only the bench watchdog ends a wait for pready
    do begin
      @(posedge mclk);
    end while (pready !== 1'h1);
    chk(32'(pready), 32'h1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task do_reset(input logic [12:0] opt);
    @(posedge mclk);
    rst <= 1'h1;
    optionWord <= opt;
    repeat (9) @(posedge mclk);
    @(negedge mclk);
    chk(32'({chipReset, upperRegClear, port6Oe, port7Oe, port9Oe, portcOe}),
      32'h3000000);
    @(posedge mclk);
    rst <= 1'h0;
    repeat (3) @(posedge mclk);
  endtask
  // Bounded wait for a reset pulse, sampled between edges
  task wait_reset;
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (chipReset !== 1'h1 && n < 10);
  endtask
  // Each row: option word, then irc erc xtal f4 pll oscin rpin rom pull
  task t_modes;
    logic [21:0] tbl [0:4] = '{{13'h1E06, 9'h105}, {13'h1E37, 9'h0AE},
      {13'h1FC6, 9'h050}, {13'h1E46, 9'h045}, {13'h1E86, 9'h105}};
    for (int i = 0; i < 5; i++) begin
      do_reset(tbl[i][21:9]);
      apb(1'h1, 8'h10, 32'h1);
      apb(1'h1, 8'h04, 32'h0);
      apb(1'h1, 8'h00, 32'h3F);
      apb(1'h0, 8'h00, 32'h0);
      chk(rdv, tbl[i][6] ? 32'h3C : 32'h3F);
      @(negedge mclk);
      chk(32'({internalRcMode, externalRcMode, crystalMode, rcFreq4m,
        pllFilterPin, pin70OscIn, resetPinMode, romAccessEnable,
        port7PullEn[0]}), 32'(tbl[i][8:0]));
      chk(32'(pllEnable), 32'(tbl[i][4]));
      chk(32'({port6Oe, port6Out}), tbl[i][6] ? 32'hF3F :
        32'hFFF);
    end
  endtask
  // Mixed directions: outputs read latch, inputs read the pin
  task t_gpio;
    do_reset(13'h1E06);
    apb(1'h1, 8'h18, 32'h0F);
    apb(1'h1, 8'h14, 32'hA5);
    @(negedge mclk);
    chk(32'({port9Oe, port9Out[7:4]}), 32'hF0A);
    repeat (5) @(posedge mclk);
    apb(1'h0, 8'h18, 32'h0);
    chk(rdv, 32'h0F);
    apb(1'h0, 8'h14, 32'h0);
    chk(rdv, 32'hAC);
    apb(1'h0, 8'h30, 32'h0);
    chk(32'(errv), 32'h1);
  endtask
  task t_pulse;
    do_reset(13'h1E06);
    apb(1'h1, 8'h24, 32'h1800);
    pulse1Out <= 1'h1;
    @(negedge mclk);
    chk(32'({portcOe, portcOut}), 32'hD);
    @(posedge mclk);
    pulse1Out <= 1'h0;
    pulse2Out <= 1'h1;
    @(negedge mclk);
    chk(32'({portcOe, portcOut}), 32'hE);
    apb(1'h1, 8'h24, 32'h0);
    @(negedge mclk);
    chk(32'(portcOe), 32'h0);
  endtask
  // Sleep, then move one port 7 pin from its set starting level to the opposite level
  task t_sleep(input logic [10:0] ctrl, input int pin, input logic from,
      input logic wake);
    do_reset(13'h1F06);
    ext7Val[pin] <= from;
    apb(1'h1, 8'h24, 32'(ctrl));
    repeat (6) @(posedge mclk);
    sleepInstr <= 1'h1;
    @(posedge mclk);
    sleepInstr <= 1'h0;
    repeat (2) @(negedge mclk);
    chk(32'(sleepActive), 32'(ctrl[10:9] == 2'h0));
    @(posedge mclk);
    ext7Val[pin] <= ~from;
    wait_reset;
    chk(32'({chipReset, upperRegClear, sleepActive}), wake ? 32'h6 :
      32'(ctrl[10:9] == 2'h0));
    @(posedge mclk);
    ext7Val <= 8'hFF;
    repeat (8) @(negedge mclk);
    chk(32'(chipReset), 32'h0);
  endtask
  task t_wdt;
    do_reset(13'h1E06);
    apb(1'h1, 8'h24, 32'h2000);
    @(negedge mclk);
    chk(32'(wdtEnable), 32'h1);
    @(posedge mclk);
    wdtTimeout <= 1'h1;
    @(posedge mclk);
    wdtTimeout <= 1'h0;
    wait_reset;
    chk(32'({chipReset, pcClear, wdtClear, upperRegClear}),
      32'hE);
    repeat (2) @(negedge mclk);
    chk(32'(wdtEnable), 32'h0);
    apb(1'h0, 8'h28, 32'h0);
    chk(rdv, 32'h00421E06);
    @(posedge mclk);
    ext7Val[1] <= 1'h0;
    repeat (8) @(negedge mclk);
    chk(32'(chipReset), 32'h1);
  endtask
  // Watchdog timeout while asleep wakes with a power-on class reset
  task t_wdt_sleep;
    do_reset(13'h1F06);
    @(posedge mclk);
    sleepInstr <= 1'h1;
    @(posedge mclk);
    sleepInstr <= 1'h0;
    wdtTimeout <= 1'h1;
    @(posedge mclk);
    wdtTimeout <= 1'h0;
    wait_reset;
    chk(32'({chipReset, upperRegClear, sleepActive}), 32'h6);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Main sequence
  initial begin
    t_modes;
    t_gpio;
    t_pulse;
    t_sleep(11'h108, 0, 1'h0, 1'h1);
    t_sleep(11'h008, 0, 1'h1, 1'h1);
    t_sleep(11'h108, 0, 1'h1, 1'h0);
    t_sleep(11'h010, 1, 1'h1, 1'h1);
    t_sleep(11'h080, 3, 1'h1, 1'h1);
    t_sleep(11'h080, 3, 1'h0, 1'h0);
    t_sleep(11'h000, 3, 1'h1, 1'h0);
    t_sleep(11'h408, 0, 1'h1, 1'h0);
    t_sleep(11'h208, 0, 1'h1, 1'h0);
    t_wdt_sleep;
    t_wdt;
    test_done;
  end
  // Hang guard, far beyond the several hundred cycles needed
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    $display("MISMATCH %0t watchdog expired", $time);
    test_done;
  end
endmodule // port_pin_config_and_wake_tb
`default_nettype wire
